// File: dcp_pkg.sv
package dcp_pkg;

  // ---------------------------------------------------------------
  // image sizes and layout
  // ---------------------------------------------------------------
  localparam int SHORT_BYTES     = 8;
  localparam int LONG_BYTES      = 12;
  localparam int FB_BYTES        = 8;
  localparam int SHORT_CH_STRIDE = 4;
  localparam int LONG_CH_STRIDE  = 6;
  localparam int FB_CH_STRIDE    = 4;

  // short layout offsets within a channel
  localparam int SHORT_SETPOINT_OFS = 0;
  localparam int SHORT_CTRL_OFS     = 2;
  localparam int SHORT_FACTOR_OFS   = 3;
  // long layout offsets within a channel
  localparam int LONG_SETPOINT_OFS  = 0;
  localparam int LONG_DELAY_OFS     = 2;
  localparam int LONG_CTRL_OFS      = 4;
  localparam int LONG_FACTOR_OFS    = 5;
  // feedback offsets within a channel
  localparam int FB_FLAGS_OFS       = 0;
  localparam int FB_SEQ_OFS         = 1;
  localparam int FB_CURRENT_OFS     = 2;

  // control bits
  localparam int CTRL_GATE_BIT   = 0;
  localparam int CTRL_DIRECT_BIT = 1;
  localparam int CTRL_LEVEL_BIT  = 2;
  localparam logic [7:0] CTRL_USED_MASK = 8'h07;

  // feedback flag bits
  localparam int FB_SUPPLY_BIT = 7;
  localparam int FB_SHORT_BIT  = 6;
  localparam int FB_PARAM_BIT  = 5;
  localparam int FB_PULSE_BIT  = 4;
  localparam int FB_ECHO_BIT   = 3;
  localparam int FB_INPUT_BIT  = 2;
  localparam int FB_OUTPUT_BIT = 1;
  localparam int FB_RUN_BIT    = 0;
  localparam logic [7:0] FB_SEQ_MASK = 8'h0F;

  // substitute feedback patterns
  localparam logic [31:0] SUBST_ONES  = 32'h07FF7FFF;
  localparam logic [31:0] SUBST_ZEROS = 32'h00000000;

  // factor scaling: effective = factor * 0.1 * configured
  localparam int FACTOR_DIV    = 10;
  localparam int RATIO_FULL    = 255;

  // time base: 1 unit = TICK_NS ns at 200 MHz
  localparam int CLK_PERIOD_NS = 5;
  localparam int TICK_NS       = 1000;
  localparam int TICK_CYCLES   = TICK_NS / CLK_PERIOD_NS;

  // host register map
  localparam logic [3:0] REG_CTRL    = 4'h0;
  localparam logic [3:0] REG_SETPT   = 4'h1;
  localparam logic [3:0] REG_DELAY   = 4'h2;
  localparam logic [3:0] REG_FACTOR  = 4'h3;
  localparam logic [3:0] REG_FLAGS   = 4'h4;
  localparam logic [3:0] REG_CURRENT = 4'h5;
  localparam logic [3:0] REG_STATUS  = 4'h6;
  localparam logic [3:0] REG_MASK    = 4'h7;
  localparam logic [3:0] REG_SEND    = 4'h8;

  typedef enum logic [2:0] {
    MODE_PULSE, MODE_PWM, MODE_TRAIN, MODE_DELAY, MODE_FREQ
  } dcp_mode_e;

endpackage

// File: dcp_if.sv
`timescale 1ns/10ps
interface dcp_if;
  logic        imageValid;
  logic        imageLong;
  logic [7:0]  ctrlImage [12];
  logic        fbValid;
  logic [7:0]  fbImage [8];

  modport host (output imageValid, output imageLong, output ctrlImage,
                input fbValid, input fbImage);
  modport unit (input imageValid, input imageLong, input ctrlImage,
                output fbValid, output fbImage);
endinterface

// File: dcp_channel.sv
`timescale 1ns/10ps
module dcp_channel (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  // decoded controls
  input  wire logic [2:0]  mode,
  input  wire logic [15:0] setpoint,
  input  wire logic [31:0] onDelay,
  input  wire logic [31:0] period,
  input  wire logic [7:0]  ratio,
  input  wire logic        gate,
  input  wire logic        direct,
  input  wire logic        level,
  input  wire logic        gateInput,
  // outputs
  output logic             outLevel,
  output logic             running
);

  typedef enum logic [1:0] {ST_IDLE, ST_DELAY, ST_RUN} dcp_st_e;

  dcp_st_e     st_q, st_d;
  logic [31:0] cnt_q, cnt_d;
  logic [31:0] ph_q, ph_d;
  logic [15:0] pulses_q, pulses_d;
  logic        gate_q, out_q, out_d;
  logic [31:0] hiTime, perTime;

  // ---------------------------------------------------------------
  // sequencing
  // ---------------------------------------------------------------
  always_comb begin
    hiTime = 32'(setpoint) * 32'(dcp_pkg::TICK_CYCLES);
    perTime = (period == 32'h0) ? 32'h1 : period;
    st_d = st_q;
    cnt_d = cnt_q;
    ph_d = ph_q;
    pulses_d = pulses_q;
    out_d = 1'b0;
    if (!gate) begin
      st_d = ST_IDLE; // RULE16
    end else begin
      unique case (st_q)
        ST_IDLE: if (!gate_q) begin
          st_d = ST_DELAY; // RULE16 RULE13
          cnt_d = 32'h0;
        end
        ST_DELAY: begin
          cnt_d = cnt_q + 32'h1;
          if (cnt_q >= onDelay) begin
            st_d = ST_RUN; // RULE11 RULE14
            cnt_d = 32'h0;
            ph_d = 32'h0;
            pulses_d = 16'h0;
          end
        end
        ST_RUN: begin
          cnt_d = cnt_q + 32'h1;
          unique case (mode)
            3'(dcp_pkg::MODE_PULSE): begin
              out_d = cnt_q < hiTime; // RULE11
              if (cnt_q >= hiTime) st_d = ST_IDLE;
            end
            3'(dcp_pkg::MODE_PWM): begin
              ph_d = (ph_q + 32'h1 >= perTime) ? 32'h0 : ph_q + 32'h1;
              out_d = ph_q < (32'(setpoint) * perTime) >> 16; // RULE14
            end
            3'(dcp_pkg::MODE_TRAIN): begin
              ph_d = (ph_q + 32'h1 >= perTime) ? 32'h0 : ph_q + 32'h1;
              out_d = ph_q < (32'(ratio) * perTime) / 32'(dcp_pkg::RATIO_FULL); // RULE17
              if (ph_q + 32'h1 >= perTime) pulses_d = pulses_q + 16'h1;
              if (pulses_q >= setpoint) st_d = ST_IDLE;
            end
            3'(dcp_pkg::MODE_DELAY): out_d = gateInput;
            default: begin
              ph_d = (ph_q + 32'h1 >= perTime) ? 32'h0 : ph_q + 32'h1;
              out_d = ph_q < (perTime >> 1);
            end
          endcase
        end
        default: st_d = ST_IDLE;
      endcase
    end
    if (direct) out_d = level; // RULE18
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= ST_IDLE;
      cnt_q <= 32'h0;
      ph_q <= 32'h0;
      pulses_q <= 16'h0;
      gate_q <= 1'b0;
      out_q <= 1'b0;
    end else begin
      st_q <= st_d;
      cnt_q <= cnt_d;
      ph_q <= ph_d;
      pulses_q <= pulses_d;
      gate_q <= gate;
      out_q <= out_d;
    end
  end

  assign outLevel = out_q;
  assign running = (st_q != ST_IDLE);

endmodule

// File: dcp_unit.sv
// Design decision made here: the strobed register port.
`timescale 1ns/10ps
// Overview of operation
// RULE1: first channel word holds mode setpoint
// RULE2: short control byte: gate, direct, level
// RULE3: short byte three/seven is scaling factor
// RULE4: long second word: on-delay or period
// RULE5: long control byte: gate, direct, level
// RULE6: long factor byte: on-delay factor, ratio
// RULE7: feedback flags byte, fault to run
// RULE8: feedback sequence nibble, upper zero
// RULE9: feedback word returns measured current
// RULE10: substitute feedback when nothing valid
// RULE11: pulse mode drives duration after delay
// RULE12: on-delay scaled by factor times 0.1
// RULE13: on-delay counted from sequence start
// RULE14: pwm output follows value after delay
// RULE15: period scaled by factor times 0.1
// RULE16: gate rising starts, clearing stops
// RULE17: train pulse width ratio/255 times period
// RULE18: direct select forces output level
// RULE19: reserved control bits ignored
module dcp_unit #(
  parameter int CHANNELS = 2,
  parameter logic [31:0] CFG_DELAY [2] = '{32'd100, 32'd100},
  parameter logic [31:0] CFG_PERIOD [2] = '{32'd1000, 32'd1000},
  parameter logic [2:0]  CFG_MODE [2] = '{3'd1, 3'd1},
  parameter bit SUBST_ALL_ONES = 1'b0
) (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  // image link
  dcp_if.unit              link,
  // field side
  input  wire logic [1:0]  gateInput,
  input  wire logic [1:0]  supplyFault,
  input  wire logic [1:0]  shortFault,
  input  wire logic [31:0] measuredCurrent,
  input  wire logic        feedbackOk,
  output logic [1:0]       outputLevel
);

  logic [7:0]  img_q [12];
  logic [7:0]  img_d [12];
  logic        long_q;
  logic        long_d;
  logic        have_q;
  logic        have_d;
  logic [3:0]  seq_q [2];
  logic [3:0]  seq_d [2];
  logic [7:0]  fb_q [8];
  logic [7:0]  fb_d [8];
  logic        fbv_q;
  logic [1:0]  outs;
  logic [1:0]  runs;
  logic [2:0]  modeC [2];
  logic [15:0] setC [2];
  logic [31:0] delC [2];
  logic [31:0] perC [2];
  logic [31:0] delLatch_q [2];
  logic [31:0] delLatch_d [2];
  logic [7:0]  ctrlC [2];
  logic [7:0]  ratC [2];

  // substitute pattern fixed per build
  localparam logic [31:0] SUBST = SUBST_ALL_ONES ? dcp_pkg::SUBST_ONES
                                                 : dcp_pkg::SUBST_ZEROS;

  // ---------------------------------------------------------------
  // helpers
  // ---------------------------------------------------------------

  function automatic logic [31:0] scale(input logic [7:0] f, input logic [31:0] base);
    scale = 32'((64'(f) * 64'(base) * 64'(dcp_pkg::TICK_CYCLES))
                / 64'(dcp_pkg::FACTOR_DIV)); // RULE12 RULE15
  endfunction

  function automatic logic [15:0] word(input int ofs);
    word = {img_q[ofs + 1], img_q[ofs]};
  endfunction

  // parameter and pulse faults stay clear
  function automatic logic [7:0] fbFlags(input int c);
    fbFlags = 8'h00;
    fbFlags[dcp_pkg::FB_SUPPLY_BIT] = supplyFault[c]; // RULE7
    fbFlags[dcp_pkg::FB_SHORT_BIT]  = shortFault[c];
    fbFlags[dcp_pkg::FB_PARAM_BIT]  = 1'b0;
    fbFlags[dcp_pkg::FB_PULSE_BIT]  = 1'b0;
    fbFlags[dcp_pkg::FB_ECHO_BIT]   = ctrlC[c][dcp_pkg::CTRL_GATE_BIT];
    fbFlags[dcp_pkg::FB_INPUT_BIT]  = gateInput[c];
    fbFlags[dcp_pkg::FB_OUTPUT_BIT] = outs[c];
    fbFlags[dcp_pkg::FB_RUN_BIT]    = runs[c];
  endfunction

  // ---------------------------------------------------------------
  // control image decode
  // ---------------------------------------------------------------
  always_comb begin
    for (int c = 0; c < 2; c++) begin
      modeC[c] = CFG_MODE[c];
      ratC[c] = 8'h0;
      if (long_q) begin
        setC[c] = word(c * dcp_pkg::LONG_CH_STRIDE + dcp_pkg::LONG_SETPOINT_OFS); // RULE1
        ctrlC[c] = img_q[c * dcp_pkg::LONG_CH_STRIDE + dcp_pkg::LONG_CTRL_OFS]; // RULE5
        delC[c] = 32'(word(c * dcp_pkg::LONG_CH_STRIDE + dcp_pkg::LONG_DELAY_OFS))
                  * 32'(dcp_pkg::TICK_CYCLES); // RULE4
        perC[c] = delC[c];
        if (modeC[c] == 3'(dcp_pkg::MODE_PWM))
          delC[c] = scale(img_q[c * dcp_pkg::LONG_CH_STRIDE + dcp_pkg::LONG_FACTOR_OFS],
                          CFG_DELAY[c]); // RULE6
        else if (modeC[c] != 3'(dcp_pkg::MODE_TRAIN))
          perC[c] = CFG_PERIOD[c] * 32'(dcp_pkg::TICK_CYCLES);
        ratC[c] = img_q[c * dcp_pkg::LONG_CH_STRIDE + dcp_pkg::LONG_FACTOR_OFS]; // RULE6
      end else begin
        setC[c] = word(c * dcp_pkg::SHORT_CH_STRIDE + dcp_pkg::SHORT_SETPOINT_OFS); // RULE1
        ctrlC[c] = img_q[c * dcp_pkg::SHORT_CH_STRIDE + dcp_pkg::SHORT_CTRL_OFS]; // RULE2
        delC[c] = scale(img_q[c * dcp_pkg::SHORT_CH_STRIDE + dcp_pkg::SHORT_FACTOR_OFS],
                        CFG_DELAY[c]); // RULE3
        perC[c] = scale(img_q[c * dcp_pkg::SHORT_CH_STRIDE + dcp_pkg::SHORT_FACTOR_OFS],
                        CFG_PERIOD[c]); // RULE3
        if (modeC[c] == 3'(dcp_pkg::MODE_PWM) || modeC[c] == 3'(dcp_pkg::MODE_TRAIN))
          delC[c] = CFG_DELAY[c] * 32'(dcp_pkg::TICK_CYCLES);
        else
          perC[c] = CFG_PERIOD[c] * 32'(dcp_pkg::TICK_CYCLES);
        ratC[c] = 8'(dcp_pkg::RATIO_FULL / 2);
      end
      ctrlC[c] = ctrlC[c] & dcp_pkg::CTRL_USED_MASK; // RULE19
      // on-delay only latched while idle
      delLatch_d[c] = runs[c] ? delLatch_q[c] : delC[c]; // RULE12
    end
  end

  // ---------------------------------------------------------------
  // channels
  // ---------------------------------------------------------------
  for (genvar g = 0; g < 2; g++) begin : gCh
    dcp_channel uCh (
      .ref_clk   (ref_clk),
      .rst_n     (rst_n),
      .mode      (modeC[g]),
      .setpoint  (setC[g]),
      .onDelay   (delLatch_d[g]),
      .period    (perC[g]),
      .ratio     (ratC[g]),
      .gate      (ctrlC[g][dcp_pkg::CTRL_GATE_BIT]),
      .direct    (ctrlC[g][dcp_pkg::CTRL_DIRECT_BIT]),
      .level     (ctrlC[g][dcp_pkg::CTRL_LEVEL_BIT]),
      .gateInput (gateInput[g]),
      .outLevel  (outs[g]),
      .running   (runs[g])
    );
  end

  // ---------------------------------------------------------------
  // image capture and feedback
  // ---------------------------------------------------------------
  always_comb begin
    img_d = img_q;
    long_d = long_q;
    have_d = have_q | link.imageValid;
    seq_d = seq_q;
    if (link.imageValid) begin
      img_d = link.ctrlImage;
      long_d = link.imageLong;
      for (int c = 0; c < 2; c++) seq_d[c] = seq_q[c] + 4'h1;
    end
    for (int c = 0; c < 2; c++) begin
      fb_d[c * dcp_pkg::FB_CH_STRIDE + dcp_pkg::FB_FLAGS_OFS] = fbFlags(c); // RULE7
      fb_d[c * dcp_pkg::FB_CH_STRIDE + dcp_pkg::FB_SEQ_OFS] =
        {4'h0, seq_q[c]} & dcp_pkg::FB_SEQ_MASK; // RULE8
      fb_d[c * dcp_pkg::FB_CH_STRIDE + dcp_pkg::FB_CURRENT_OFS] =
        measuredCurrent[c * 16 +: 8]; // RULE9
      fb_d[c * dcp_pkg::FB_CH_STRIDE + dcp_pkg::FB_CURRENT_OFS + 1] =
        measuredCurrent[c * 16 + 8 +: 8]; // RULE9
    end
    if (!feedbackOk || !have_q) begin
      for (int b = 0; b < 4; b++) begin
        fb_d[b] = SUBST[b * 8 +: 8]; // RULE10
        fb_d[b + 4] = fb_d[b];
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      img_q <= '{default: 8'h00};
      fb_q <= '{default: 8'h00};
      seq_q <= '{default: 4'h0};
      delLatch_q <= '{default: 32'h0};
      long_q <= 1'b0;
      have_q <= 1'b0;
      fbv_q <= 1'b0;
      outputLevel <= 2'b00;
    end else begin
      img_q <= img_d;
      fb_q <= fb_d;
      seq_q <= seq_d;
      delLatch_q <= delLatch_d;
      long_q <= long_d;
      have_q <= have_d;
      fbv_q <= have_q & feedbackOk;
      outputLevel <= outs;
    end
  end

  assign link.fbImage = fb_q;
  assign link.fbValid = fbv_q;

endmodule

// File: dcp_host.sv
`timescale 1ns/10ps
module dcp_host (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst_n,
  // software port
  input  wire logic [3:0]  addr,
  input  wire logic [31:0] wrData,
  input  wire logic        wrStb,
  input  wire logic        rdStb,
  output logic [31:0]      rdData,
  output logic             irq,
  // image link
  dcp_if.host              link
);

  logic [31:0] ctrl_q, ctrl_d, setp_q, setp_d, dly_q, dly_d, fac_q, fac_d;
  logic [31:0] rd_q, rd_d;
  logic [1:0]  sts_q, sts_d, msk_q, msk_d;
  logic        send_q, send_d, irq_q;
  logic [7:0]  flagsPrev_q;

  // ---------------------------------------------------------------
  // register port; ctrl bit 8 selects long image
  // ---------------------------------------------------------------
  always_comb begin
    ctrl_d = ctrl_q;
    setp_d = setp_q;
    dly_d = dly_q;
    fac_d = fac_q;
    msk_d = msk_q;
    send_d = 1'b0;
    rd_d = 32'h0;
    // events: feedback update, channel 0 fault bit change
    sts_d = sts_q | {link.fbImage[0][7:4] != flagsPrev_q[7:4], link.fbValid};
    if (wrStb) begin
      unique case (addr)
        dcp_pkg::REG_CTRL:   ctrl_d = wrData;
        dcp_pkg::REG_SETPT:  setp_d = wrData;
        dcp_pkg::REG_DELAY:  dly_d = wrData;
        dcp_pkg::REG_FACTOR: fac_d = wrData;
        dcp_pkg::REG_STATUS: sts_d = (sts_q & ~wrData[1:0]) |
          {link.fbImage[0][7:4] != flagsPrev_q[7:4], link.fbValid};
        dcp_pkg::REG_MASK:   msk_d = wrData[1:0];
        dcp_pkg::REG_SEND:   send_d = 1'b1;
        default: ;
      endcase
    end
    if (rdStb) begin
      unique case (addr)
        dcp_pkg::REG_CTRL:    rd_d = ctrl_q;
        dcp_pkg::REG_SETPT:   rd_d = setp_q;
        dcp_pkg::REG_DELAY:   rd_d = dly_q;
        dcp_pkg::REG_FACTOR:  rd_d = fac_q;
        dcp_pkg::REG_FLAGS:   rd_d = {link.fbImage[5], link.fbImage[4],
                                      link.fbImage[1], link.fbImage[0]};
        dcp_pkg::REG_CURRENT: rd_d = {link.fbImage[7], link.fbImage[6],
                                      link.fbImage[3], link.fbImage[2]};
        dcp_pkg::REG_STATUS:  rd_d = {30'h0, sts_q};
        dcp_pkg::REG_MASK:    rd_d = {30'h0, msk_q};
        default: rd_d = 32'h0;
      endcase
    end
  end

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      ctrl_q <= 32'h0;
      setp_q <= 32'h0;
      dly_q <= 32'h0;
      fac_q <= 32'h0;
      rd_q <= 32'h0;
      sts_q <= 2'h0;
      msk_q <= 2'h0;
      send_q <= 1'b0;
      irq_q <= 1'b0;
      flagsPrev_q <= 8'h00;
    end else begin
      ctrl_q <= ctrl_d;
      setp_q <= setp_d;
      dly_q <= dly_d;
      fac_q <= fac_d;
      rd_q <= rd_d;
      sts_q <= sts_d;
      msk_q <= msk_d;
      send_q <= send_d;
      irq_q <= |(sts_d & msk_d);
      flagsPrev_q <= link.fbImage[0];
    end
  end

  // ---------------------------------------------------------------
  // image assembly; reserved control bits sent as zero
  // ---------------------------------------------------------------
  always_comb begin
    link.ctrlImage = '{default: 8'h00};
    if (ctrl_q[8]) begin
      for (int c = 0; c < 2; c++) begin
        link.ctrlImage[c * 6 + 0] = setp_q[c * 16 +: 8]; // RULE1
        link.ctrlImage[c * 6 + 1] = setp_q[c * 16 + 8 +: 8];
        link.ctrlImage[c * 6 + 2] = dly_q[c * 16 +: 8]; // RULE4
        link.ctrlImage[c * 6 + 3] = dly_q[c * 16 + 8 +: 8];
        link.ctrlImage[c * 6 + 4] = ctrl_q[c * 4 +: 8] & dcp_pkg::CTRL_USED_MASK; // RULE5
        link.ctrlImage[c * 6 + 5] = fac_q[c * 8 +: 8]; // RULE6
      end
    end else begin
      for (int c = 0; c < 2; c++) begin
        link.ctrlImage[c * 4 + 0] = setp_q[c * 16 +: 8]; // RULE1
        link.ctrlImage[c * 4 + 1] = setp_q[c * 16 + 8 +: 8];
        link.ctrlImage[c * 4 + 2] = ctrl_q[c * 4 +: 8] & dcp_pkg::CTRL_USED_MASK; // RULE2
        link.ctrlImage[c * 4 + 3] = fac_q[c * 8 +: 8]; // RULE3
      end
    end
  end

  assign link.imageValid = send_q;
  assign link.imageLong = ctrl_q[8];
  assign rdData = rd_q;
  assign irq = irq_q;

endmodule

// File: dcp_checker.sv
`timescale 1ns/10ps
module dcp_checker (
  // clock and reset
  input wire logic       ref_clk,
  input wire logic       rst_n,
  // image link
  input wire logic       imageValid,
  input wire logic       imageLong,
  input wire logic [7:0] ctrlImage [12],
  input wire logic       fbValid,
  input wire logic [7:0] fbImage [8]
);
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!rst_n);

  // ----------------------------------------------------------------
  // gate bits of the image as sent
  // ----------------------------------------------------------------
  logic gate0;
  logic gate1;
  assign gate0 = imageLong ? ctrlImage[4][0] : ctrlImage[2][0];
  assign gate1 = imageLong ? ctrlImage[10][0] : ctrlImage[6][0];

  sequence s_fresh;
    imageValid ##3 fbValid;
  endsequence
  sequence s_chained;
    (imageValid && fbValid) ##3 fbValid;
  endsequence

  AST_SEQ_UPPER_ZERO:
    assert property (fbImage[1][7:4] == 4'h0 && fbImage[5][7:4] == 4'h0)
    else $error("sequence byte upper nibble not zero");
  AST_SEQ_PAIR:
    assert property (fbValid |-> fbImage[5][3:0] == fbImage[1][3:0])
    else $error("channel sequence counters differ");
  AST_SEQ_STEP:
    assert property (s_chained |-> fbImage[1][3:0] == $past(fbImage[1][3:0], 3) + 4'h1)
    else $error("sequence counter did not step by one");
  AST_ECHO_GATE:
    assert property (s_fresh |-> fbImage[0][3] == gate0 && fbImage[4][3] == gate1)
    else $error("gate echo differs from image");
  AST_SUBST_ZERO:
    assert property (!fbValid |-> {fbImage[3], fbImage[2], fbImage[1], fbImage[0]}
      == dcp_pkg::SUBST_ZEROS && {fbImage[7], fbImage[6], fbImage[5], fbImage[4]} == 32'h0)
    else $error("substitute feedback not zero");
  AST_SHORT_RESERVED:
    assert property (imageValid && !imageLong |-> ctrlImage[2][7:3] == 5'h00
      && ctrlImage[6][7:3] == 5'h00)
    else $error("short control reserved bits set");
  AST_LONG_RESERVED:
    assert property (imageValid && imageLong |-> ctrlImage[4][7:3] == 5'h00
      && ctrlImage[10][7:3] == 5'h00)
    else $error("long control reserved bits set");
  AST_FAULT_BITS:
    assert property (fbValid |-> fbImage[0][5:4] == 2'h0 && fbImage[4][5:4] == 2'h0)
    else $error("parameter or pulse fault bit set");
endmodule

// File: tb.sv
`timescale 1ns/10ps
module tb;
  // ----------------------------------------------------------------
  // signals and instances
  // ----------------------------------------------------------------
  logic        ref_clk;
  logic        rst_n           = 1'h0;
  logic [3:0]  addr            = 4'h0;
  logic [31:0] wrData          = 32'h0;
  logic        wrStb           = 1'h0;
  logic        rdStb           = 1'h0;
  logic [31:0] rdData;
  logic        irq;
  logic [1:0]  gateInput       = 2'h0;
  logic [1:0]  supplyFault     = 2'h0;
  logic [1:0]  shortFault      = 2'h0;
  logic [31:0] measuredCurrent = 32'h0;
  logic        feedbackOk      = 1'h1;
  logic [1:0]  outputLevel;
  logic [31:0] seed            = 32'h000005CC;
  logic [31:0] rdv;
  logic [31:0] r;
  logic [31:0] cur;
  logic [31:0] ex;
  int          nFail           = 0;
  int          compares        = 0;
  int          cyc             = 0;
  int          nImg            = 0;

  dcp_if link ();
  dcp_host dcp_host_inst (.ref_clk(ref_clk), .rst_n(rst_n), .addr(addr), .wrData(wrData),
    .wrStb(wrStb), .rdStb(rdStb), .rdData(rdData), .irq(irq), .link(link.host));
  dcp_unit #(.CFG_DELAY('{32'h2, 32'h1}), .CFG_PERIOD('{32'h2, 32'h2}),
    .CFG_MODE('{3'(dcp_pkg::MODE_PULSE), 3'(dcp_pkg::MODE_PWM)})) dcp_unit_inst (
    .ref_clk(ref_clk), .rst_n(rst_n), .link(link.unit), .gateInput(gateInput),
    .supplyFault(supplyFault), .shortFault(shortFault), .measuredCurrent(measuredCurrent),
    .feedbackOk(feedbackOk), .outputLevel(outputLevel));
  dcp_checker dcp_checker_inst (.ref_clk(ref_clk), .rst_n(rst_n),
    .imageValid(link.imageValid), .imageLong(link.imageLong), .ctrlImage(link.ctrlImage),
    .fbValid(link.fbValid), .fbImage(link.fbImage));

  initial begin
    ref_clk = 1'h0;
    forever #2.5 ref_clk = ~ref_clk;
  end

  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 60000) begin
      nFail++;
      finish_test();
    end
  end

  // ----------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction

  function automatic logic [31:0] ctrlw(logic lng, logic [2:0] c0, logic [2:0] c1,
                                        logic [1:0] junk);
    return {23'h0, lng, junk[1], c1, junk[0], c0};
  endfunction

  function automatic logic [7:0] expF(logic sup, logic sh, logic g, logic gin, logic o);
    return {sup, sh, 2'h0, g, gin, o, 1'h0};
  endfunction

  function automatic logic [31:0] inTol(int v, int e);
    return {31'h0, (v >= e - 8) && (v <= e + 8)};
  endfunction

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp) begin
      nFail++;
      $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask

  task automatic tick(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask

  task automatic wr(input logic [3:0] a, input logic [31:0] d);
    @(posedge ref_clk);
    addr   <= a;
    wrData <= d;
    wrStb  <= 1'h1;
    @(posedge ref_clk);
    wrStb  <= 1'h0;
  endtask

  task automatic rd(input logic [3:0] a, output logic [31:0] d);
    @(posedge ref_clk);
    addr  <= a;
    rdStb <= 1'h1;
    @(posedge ref_clk);
    rdStb <= 1'h0;
    #1;
    d = rdData;
  endtask

  task automatic send();
    wr(dcp_pkg::REG_SEND, 32'h1);
    nImg++;
    tick(6);
  endtask

  // on-delay and pulse width of channel 0, optionally cut short by the gate
  task automatic pulse_run(input logic lng, input logic [7:0] fac, input logic [15:0] dly,
                           input int expUs, input logic abort);
    int n;
    wr(dcp_pkg::REG_CTRL, ctrlw(lng, 3'h0, 3'h0, 2'h3));
    wr(dcp_pkg::REG_SETPT, {16'h0, abort ? 16'h5 : 16'h1});
    wr(dcp_pkg::REG_DELAY, {16'h0, dly});
    wr(dcp_pkg::REG_FACTOR, {24'h0, fac});
    send();
    wr(dcp_pkg::REG_CTRL, ctrlw(lng, 3'h1, 3'h0, 2'h0));
    wr(dcp_pkg::REG_SEND, 32'h1);
    nImg++;
    n = 0;
    while (outputLevel[0] !== 1'h1 && n < 3000) begin
      tick(1);
      n++;
    end
    check(inTol(n, expUs * dcp_pkg::TICK_CYCLES), 32'h1);
    n = 0;
    while (outputLevel[0] === 1'h1 && n < (abort ? 50 : 3000)) begin
      tick(1);
      n++;
    end
    if (abort) begin
      wr(dcp_pkg::REG_CTRL, ctrlw(lng, 3'h0, 3'h0, 2'h0));
      send();
      check({31'h0, outputLevel[0]}, 32'h0);
    end else begin
      check(inTol(n, dcp_pkg::TICK_CYCLES), 32'h1);
    end
  endtask

  // high time of channel 1 over a whole number of periods
  task automatic pwm_run(input logic [7:0] fac, input logic [15:0] sp, input int expHigh);
    int h;
    wr(dcp_pkg::REG_CTRL, ctrlw(1'h0, 3'h0, 3'h0, 2'h0));
    wr(dcp_pkg::REG_SETPT, {sp, 16'h0});
    wr(dcp_pkg::REG_FACTOR, {16'h0, fac, 8'h0});
    send();
    wr(dcp_pkg::REG_CTRL, ctrlw(1'h0, 3'h0, 3'h1, 2'h0));
    send();
    tick(400);
    h = 0;
    for (int k = 0; k < 1600; k++) begin
      tick(1);
      if (outputLevel[1] === 1'h1) h++;
    end
    check(inTol(h, expHigh), 32'h1);
  endtask

  task automatic finish_test();
    if (nFail == 0 && compares > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask

  // ----------------------------------------------------------------
  // main sequence
  // ----------------------------------------------------------------
  initial begin
    repeat (20) @(posedge ref_clk);
    rst_n <= 1'h1;
    rd(dcp_pkg::REG_FLAGS, rdv);
    check(rdv, 32'h0);
    rd(dcp_pkg::REG_CURRENT, rdv);
    check(rdv, 32'h0);
    rd(4'hF, rdv);
    check(rdv, 32'h0);
    for (int i = 0; i < 20; i++) begin
      r = rnd();
      cur = rnd();
      @(posedge ref_clk);
      supplyFault     <= r[6:5];
      shortFault      <= r[8:7];
      gateInput       <= r[10:9];
      measuredCurrent <= cur;
      wr(dcp_pkg::REG_CTRL, ctrlw(r[0], {r[1], 1'h1, r[2]}, {r[3], 1'h1, r[4]}, r[12:11]));
      send();
      check({30'h0, outputLevel}, {30'h0, r[3], r[1]});
      ex[31:16] = {4'h0, nImg[3:0], expF(r[6], r[8], r[4], r[10], r[3])};
      ex[15:0] = {4'h0, nImg[3:0], expF(r[5], r[7], r[2], r[9], r[1])};
      rd(dcp_pkg::REG_FLAGS, rdv);
      check(rdv & 32'hFFFEFFFE, ex);
      rd(dcp_pkg::REG_CURRENT, rdv);
      check(rdv, cur);
      rd(dcp_pkg::REG_STATUS, rdv);
      check(rdv & 32'h1, 32'h1);
    end
    wr(dcp_pkg::REG_MASK, 32'h0);
    wr(dcp_pkg::REG_STATUS, 32'h3);
    tick(2);
    check({31'h0, irq}, 32'h0);
    @(posedge ref_clk);
    supplyFault <= ~supplyFault;
    send();
    rd(dcp_pkg::REG_STATUS, rdv);
    check(rdv & 32'h2, 32'h2);
    check({31'h0, irq}, 32'h0);
    wr(dcp_pkg::REG_MASK, 32'h2);
    tick(1);
    check({31'h0, irq}, 32'h1);
    wr(dcp_pkg::REG_STATUS, 32'h2);
    tick(1);
    check({31'h0, irq}, 32'h0);
    pulse_run(1'h0, 8'h05, 16'h0, 1, 1'h0);
    pulse_run(1'h0, 8'h19, 16'h0, 5, 1'h0);
    pulse_run(1'h1, 8'h4D, 16'h3, 3, 1'h0);
    pulse_run(1'h0, 8'h0A, 16'h0, 2, 1'h1);
    pwm_run(8'h0A, 16'h4000, 400);
    pwm_run(8'h14, 16'hC000, 1200);
    @(posedge ref_clk);
    feedbackOk <= 1'h0;
    tick(6);
    rd(dcp_pkg::REG_FLAGS, rdv);
    check(rdv, 32'h0);
    rd(dcp_pkg::REG_CURRENT, rdv);
    check(rdv, 32'h0);
    wr(dcp_pkg::REG_STATUS, 32'h1);
    rd(dcp_pkg::REG_STATUS, rdv);
    check(rdv & 32'h1, 32'h0);
    finish_test();
  end
endmodule
